// *** common/pmsc_pkg.sv ***
// ------------------------------------------------------------
// register map and field layout
// ------------------------------------------------------------
package pmsc_pkg;

   // register addresses seen by the pointer
   localparam logic [15:0] ADDR_STATUS  = 16'h0002;
   localparam logic [15:0] ADDR_VERSION = 16'h0004;
   localparam logic [15:0] ADDR_CONFIG  = 16'h0042;
   localparam logic [15:0] PTR_RESET    = 16'h0000;

   // status bit positions
   localparam int ST_EVENT = 10;
   localparam int ST_REACT = 5;
   localparam int ST_ACT   = 4;
   localparam int ST_OVP   = 3;
   localparam int ST_OVC   = 2;
   localparam int ST_SURGE = 1;
   localparam int ST_SAG   = 0;

   // implemented status bits; everything else reads zero
   localparam logic [15:0] STATUS_MASK = 16'h043F;

   // configuration field positions
   localparam int CF_GAIN1_LSB = 27;
   localparam int CF_GAIN0_LSB = 24;
   localparam int CF_TRIM_LSB  = 16;
   localparam int CF_RST_LSB   = 5;
   localparam int CF_SHDN_LSB  = 3;

   // configuration value after reset and writable bits
   localparam logic [31:0] CFG_RESET = 32'h0042_0000;
   localparam logic [31:0] CFG_WMASK = 32'h3FFF_9CFC;
   localparam logic [7:0]  TRIM_RESET = 8'h42;

   // gain word after reset (gain of one)
   localparam logic [5:0] GAIN_ONE = 6'h01;

   // host commands
   typedef enum logic [1:0] {
      PMSC_OP_SET_PTR,
      PMSC_OP_WRITE,
      PMSC_OP_READ,
      PMSC_OP_CLEAR
   } pmsc_op_t;

endpackage

// *** common/pmsc_flag_if.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// sticky flag set / clear bundle
// ------------------------------------------------------------
interface pmsc_flag_if #(
   parameter int N = 3
);
   logic [N-1:0] set;
   logic [N-1:0] clr;
   logic [N-1:0] flag;

   modport owner (input set, input clr, output flag);
   modport user  (output set, output clr, input flag);
endinterface

// *** design/pmsc_flag_latch.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// sticky flags: a set in the clearing cycle wins
// ------------------------------------------------------------
module pmsc_flag_latch #(
   parameter int N = 3
) (
   // clock and reset
   input wire logic   ref_clk,
   input wire logic   rst,
   // flags
   pmsc_flag_if.owner fl
);

   if (N < 1) begin : g_chk
      $error("flag count must be at least one");
   end

   // hold until cleared; new detection overrides clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fl.flag <= '0;
      end else begin
         fl.flag <= fl.set | (fl.flag & ~fl.clr); // [R16]
      end
   end

   a_flag_hold: assert property ( // [R1]
      @(posedge ref_clk) disable iff (rst)
      fl.flag[0] && !fl.clr[0] |=> fl.flag[0])
      else $error("flag dropped without clear");

   a_set_wins: assert property ( // [R16]
      @(posedge ref_clk) disable iff (rst)
      fl.set[0] && fl.clr[0] |=> fl.flag[0])
      else $error("set lost against clear");

endmodule

// *** design/pmsc_gain_dec.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// amplifier gain decode for one channel
// ------------------------------------------------------------
module pmsc_gain_dec (
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // gain code and decoded gain in v/v
   input  wire logic [2:0] code,
   output logic      [5:0] gain
);

   // undefined codes fall back to unity gain
   function automatic logic [5:0] gain_of(input logic [2:0] c);
      logic [5:0] g;
      g = pmsc_pkg::GAIN_ONE;
      if (c <= 3'h5) begin
         g = pmsc_pkg::GAIN_ONE << c; // [R10]
      end
      return g; // [R11]
   endfunction

   // registered so the top output comes from a flop
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         gain <= pmsc_pkg::GAIN_ONE;
      end else begin
         gain <= gain_of(code); // [R10]
      end
   end

   a_gain_eight: assert property ( // [R10]
      @(posedge ref_clk) disable iff (rst)
      code == 3'h3 |=> gain == 6'h08)
      else $error("code 3 did not give gain 8");

   a_gain_undef: assert property ( // [R11]
      @(posedge ref_clk) disable iff (rst)
      code[2:1] == 2'h3 |=> gain == 6'h01)
      else $error("undefined code not unity gain");

endmodule

// *** design/pmsc_status_config.sv ***
`timescale 1ns/1ns
// Overview of operation
// [R1] The event flag in status bit 10 sets on detection and holds until cleared.
// [R2] Status bit 5 is 1 for positive (inductive) reactive power, else 0.
// [R3] Status bit 4 is 1 for positive (import) active power, else 0.
// [R4] Status bit 3 follows the over-power detector live, never latched.
// [R5] Status bit 2 follows the over-current detector live.
// [R6] Status bit 1 latches a voltage surge until cleared.
// [R7] Status bit 0 latches a voltage sag until cleared.
// [R8] Status is read-only and bits 15..11 and 9..6 always read zero.
// [R9] The version register returns a fixed year-month-day-day date code.
// [R10] Each channel's three-bit gain code 0..5 selects gain 1,2,4,8,16,32.
// [R11] Gain codes 110 and 111 act as a gain of one.
// [R12] The two soft-reset bits alone force converter outputs to zero.
// [R13] Each converter has its own shutdown bit; writing 0 re-enables it.
// [R14] The drift trim sits in the configuration register, reset 0x42.
// [R15] Only the set-pointer command moves the pointer; accesses use it.
// [R16] A clear drops a latched flag unless it recurs in the same cycle.
module pmsc_status_config #(
   // date code, value arbitrary
   parameter logic [15:0] VERSION_CODE = 16'h1A27
) (
   // clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst,

   // host commands from the serial front end
   input  wire logic               cmd_valid,
   input  wire pmsc_pkg::pmsc_op_t cmd_op,
   input  wire logic        [31:0] cmd_data,

   // command answer
   output logic                    rsp_valid,
   output logic             [31:0] rsp_data,
   output logic                    rsp_err,

   // detector inputs, same clock
   input  wire logic               event_detect,
   input  wire logic               voltage_rise_detect,
   input  wire logic               voltage_dip_detect,
   input  wire logic               reactive_power_polarity,
   input  wire logic               active_power_polarity,
   input  wire logic               power_limit_exceeded,
   input  wire logic               current_limit_exceeded,

   // register state
   output logic             [15:0] status_word,
   output logic             [15:0] addr_pointer,

   // front-end controls
   output logic              [5:0] ch0_gain,
   output logic              [5:0] ch1_gain,
   output logic              [1:0] adc_force_zero,
   output logic              [1:0] adc_shutdown,
   output logic              [7:0] reference_drift_trim
);

   // ------------------------------------------------------------
   // parameter checks
   // ------------------------------------------------------------

   // day digits must be decimal and the month a real month
   if (VERSION_CODE[3:0] > 4'h9 || VERSION_CODE[7:4] > 4'h3 ||
       VERSION_CODE[11:8] == 4'h0 || VERSION_CODE[11:8] > 4'hC)
   begin : g_chk
      $error("version code is not a valid date code");
   end

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------

   logic        do_ptr;
   logic        do_wr;
   logic        do_rd;
   logic        do_clr;
   logic        at_cfg;
   logic        at_status;
   logic        at_version;
   logic [15:0] ptr_q;

   // one-cycle strobes per command kind
   assign do_ptr = cmd_valid && cmd_op == pmsc_pkg::PMSC_OP_SET_PTR;
   assign do_wr  = cmd_valid && cmd_op == pmsc_pkg::PMSC_OP_WRITE;
   assign do_rd  = cmd_valid && cmd_op == pmsc_pkg::PMSC_OP_READ;
   assign do_clr = cmd_valid && cmd_op == pmsc_pkg::PMSC_OP_CLEAR;

   // every access targets the pointer, never cmd_data
   assign at_cfg     = ptr_q == pmsc_pkg::ADDR_CONFIG; // [R15]
   assign at_status  = ptr_q == pmsc_pkg::ADDR_STATUS;
   assign at_version = ptr_q == pmsc_pkg::ADDR_VERSION;

   // ------------------------------------------------------------
   // address pointer
   // ------------------------------------------------------------

   // only the set-pointer command moves it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ptr_q <= pmsc_pkg::PTR_RESET;
      end else if (do_ptr) begin
         ptr_q <= cmd_data[15:0]; // [R15]
      end
   end

   assign addr_pointer = ptr_q;

   // ------------------------------------------------------------
   // live status bits
   // ------------------------------------------------------------

   logic [3:0] live_q;

   // sampled every cycle, nothing held
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         live_q <= 4'h0;
      end else begin
         live_q[3] <= reactive_power_polarity; // [R2]
         live_q[2] <= active_power_polarity;   // [R3]
         live_q[1] <= power_limit_exceeded;    // [R4]
         live_q[0] <= current_limit_exceeded;  // [R5]
      end
   end

   // ------------------------------------------------------------
   // latched status flags
   // ------------------------------------------------------------

   pmsc_flag_if #(.N(3)) flags ();

   // flag order: 2 event, 1 surge, 0 sag
   assign flags.set[2] = event_detect;        // [R1]
   assign flags.set[1] = voltage_rise_detect; // [R6]
   assign flags.set[0] = voltage_dip_detect;  // [R7]

   // clear mask uses the status bit positions
   assign flags.clr[2] = do_clr && cmd_data[pmsc_pkg::ST_EVENT];
   assign flags.clr[1] = do_clr && cmd_data[pmsc_pkg::ST_SURGE];
   assign flags.clr[0] = do_clr && cmd_data[pmsc_pkg::ST_SAG];

   pmsc_flag_latch #(
      .N       (3)
   ) u_flags (
      .ref_clk (ref_clk),
      .rst     (rst),
      .fl      (flags)
   );

   // ------------------------------------------------------------
   // status word
   // ------------------------------------------------------------

   // unused positions tied to zero, no write path exists
   always_comb begin
      status_word = 16'h0000; // [R8]
      status_word[pmsc_pkg::ST_EVENT] = flags.flag[2];
      status_word[pmsc_pkg::ST_REACT] = live_q[3];
      status_word[pmsc_pkg::ST_ACT]   = live_q[2];
      status_word[pmsc_pkg::ST_OVP]   = live_q[1];
      status_word[pmsc_pkg::ST_OVC]   = live_q[0];
      status_word[pmsc_pkg::ST_SURGE] = flags.flag[1];
      status_word[pmsc_pkg::ST_SAG]   = flags.flag[0];
   end

   // ------------------------------------------------------------
   // configuration register
   // ------------------------------------------------------------

   logic [31:0] cfg_q;

   // unimplemented bits are masked so they read back as zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_q <= pmsc_pkg::CFG_RESET; // [R14]
      end else if (do_wr && at_cfg) begin
         cfg_q <= cmd_data & pmsc_pkg::CFG_WMASK; // [R12] [R13]
      end
   end

   // per-converter bits straight from the register
   assign adc_force_zero = cfg_q[pmsc_pkg::CF_RST_LSB +: 2];  // [R12]
   assign adc_shutdown   = cfg_q[pmsc_pkg::CF_SHDN_LSB +: 2]; // [R13]
   assign reference_drift_trim =
      cfg_q[pmsc_pkg::CF_TRIM_LSB +: 8]; // [R14]

   // ------------------------------------------------------------
   // gain decode per channel
   // ------------------------------------------------------------

   pmsc_gain_dec u_gain0 (
      .ref_clk (ref_clk),
      .rst     (rst),
      .code    (cfg_q[pmsc_pkg::CF_GAIN0_LSB +: 3]),
      .gain    (ch0_gain)
   );

   pmsc_gain_dec u_gain1 (
      .ref_clk (ref_clk),
      .rst     (rst),
      .code    (cfg_q[pmsc_pkg::CF_GAIN1_LSB +: 3]),
      .gain    (ch1_gain)
   );

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------

   logic [31:0] rd_val;
   logic        rd_hit;

   // unmapped addresses read as zero and flag an error
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      if (at_status) begin
         rd_val = {16'h0000, status_word & pmsc_pkg::STATUS_MASK};
      end else if (at_version) begin
         rd_val = {16'h0000, VERSION_CODE}; // [R9]
      end else if (at_cfg) begin
         rd_val = cfg_q;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // answer
   // ------------------------------------------------------------

   // one answer per command, one cycle later; status is read-only
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_data  <= 32'h0000_0000;
         rsp_err   <= 1'b0;
      end else begin
         rsp_valid <= cmd_valid;
         rsp_data  <= do_rd ? rd_val : 32'h0000_0000;
         rsp_err   <= (do_rd && !rd_hit) ||
                      (do_wr && !at_cfg); // [R8]
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------

   default clocking cb @(posedge ref_clk);
   endclocking

   default disable iff (rst);

   a_event_sets: assert property ( // [R1]
      event_detect |=> status_word[10])
      else $error("event not latched");

   a_react_sign: assert property ( // [R2]
      1'b1 |=> status_word[5] == $past(reactive_power_polarity))
      else $error("reactive sign wrong");

   a_active_sign: assert property ( // [R3]
      1'b1 |=> status_word[4] == $past(active_power_polarity))
      else $error("active sign wrong");

   a_power_live: assert property ( // [R4]
      !power_limit_exceeded |=> !status_word[3])
      else $error("over-power held after drop");

   a_current_live: assert property ( // [R5]
      current_limit_exceeded |=> status_word[2])
      else $error("over-current not shown");

   a_surge_hold: assert property ( // [R6]
      voltage_rise_detect ##1 !do_clr [*2] |-> status_word[1])
      else $error("surge flag not held");

   a_sag_hold: assert property ( // [R7]
      voltage_dip_detect ##1 !do_clr [*2] |-> status_word[0])
      else $error("sag flag not held");

   a_status_zero: assert property ( // [R8]
      do_rd && at_status |=> rsp_data[31:11] == 21'h0 &&
      rsp_data[9:6] == 4'h0 && !rsp_err)
      else $error("unused status bits not zero");

   a_version_read: assert property ( // [R9]
      do_rd && at_version |=> rsp_data == {16'h0000, VERSION_CODE})
      else $error("version read wrong");

   a_soft_reset: assert property ( // [R12]
      do_wr && at_cfg && cmd_data[6:5] == 2'h3 |=> adc_force_zero == 2'h3)
      else $error("soft reset not entered");

   a_shutdown_off: assert property ( // [R13]
      do_wr && at_cfg && !cmd_data[3] |=> !adc_shutdown[0])
      else $error("converter not re-enabled");

   a_trim_reset: assert property ( // [R14]
      $past(rst) |-> reference_drift_trim == pmsc_pkg::TRIM_RESET)
      else $error("trim reset value wrong");

   a_ptr_stable: assert property ( // [R15]
      !do_ptr |=> $stable(addr_pointer))
      else $error("pointer moved without command");

   a_clear_drops: assert property ( // [R16]
      do_clr && cmd_data[0] && !voltage_dip_detect |=> !status_word[0])
      else $error("sag flag survived clear");

endmodule

// *** tb/pmsc_host.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// host model: serial front end issuing one command at a time
// ------------------------------------------------------------
module pmsc_host (
   // clock
   input  wire logic               ref_clk,
   // command side
   output logic                    cmd_valid,
   output pmsc_pkg::pmsc_op_t      cmd_op,
   output logic            [31:0]  cmd_data,
   // answer side
   input  wire logic               rsp_valid,
   input  wire logic       [31:0]  rsp_data,
   input  wire logic               rsp_err
);
   // idle at time zero, data parked on a pattern
   initial begin
      cmd_valid = 1'b0;
      cmd_op    = pmsc_pkg::PMSC_OP_READ;
      cmd_data  = 32'h5A5A_A5A5;
   end

   // gap idles the host for slow traffic; the pointer is only moved
   // by a set-pointer command and a flag only dropped by a clear
   task automatic xfer(input pmsc_pkg::pmsc_op_t op,
                       input logic [31:0] d, input int gap,
                       output logic [31:0] rd, output logic err,
                       output logic ok);
      repeat (gap) @(negedge ref_clk);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_op    = op;
      cmd_data  = d;
      @(posedge ref_clk);
      @(negedge ref_clk);
      // answer stands one cycle: take it now, then release
      ok        = rsp_valid;
      rd        = rsp_data;
      err       = rsp_err;
      cmd_valid = 1'b0;
      cmd_data  = ~d; // released data no longer holds its value
   endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("[ERR] %s exp=%h got=%h", nm, e, g); \
   end \
end
// ------------------------------------------------------------
// bench for the status and configuration registers
// ------------------------------------------------------------
module testbench;
   localparam logic [15:0] VER = 16'h2315; // date code, value arbitrary
   logic               ref_clk = 1'b0;
   logic               rst = 1'b1;
   logic               ev_d = 1'b0, rise_d = 1'b0, dip_d = 1'b0;
   logic               rpol = 1'b0, apol = 1'b0, pwr = 1'b0, cur = 1'b0;
   logic               cmd_valid, rsp_valid, rsp_err, err, ok;
   pmsc_pkg::pmsc_op_t cmd_op;
   logic        [31:0] cmd_data, rsp_data, rd, d;
   logic        [15:0] status_word, addr_pointer, exp_st;
   logic         [5:0] ch0_gain, ch1_gain;
   logic         [1:0] adc_force_zero, adc_shutdown;
   logic         [7:0] reference_drift_trim;
   int                 bad_count = 0, n_tests = 0, cycles = 0;
   integer             seed = 32'hdd996608;
   logic               live_chk = 1'b0;
   wire         [15:0] clr_m = (cmd_valid && cmd_op ==
                                pmsc_pkg::PMSC_OP_CLEAR) ?
                               cmd_data[15:0] : 16'h0000;

   always #4 ref_clk = ~ref_clk;

   pmsc_status_config #(.VERSION_CODE(VER)) dut (
      .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_err(rsp_err), .event_detect(ev_d),
      .voltage_rise_detect(rise_d), .voltage_dip_detect(dip_d),
      .reactive_power_polarity(rpol), .active_power_polarity(apol),
      .power_limit_exceeded(pwr), .current_limit_exceeded(cur),
      .status_word(status_word), .addr_pointer(addr_pointer),
      .ch0_gain(ch0_gain), .ch1_gain(ch1_gain),
      .adc_force_zero(adc_force_zero), .adc_shutdown(adc_shutdown),
      .reference_drift_trim(reference_drift_trim));

   pmsc_host host (
      .ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_err(rsp_err));

   // expected status: live bits one edge late, sticky bits set-wins
   always @(posedge ref_clk) begin
      if (rst)
         exp_st <= 16'h0000;
      else
         exp_st <= {5'h00, ev_d | exp_st[10] & ~clr_m[10], 4'h0,
                    rpol, apol, pwr, cur,
                    rise_d | exp_st[1] & ~clr_m[1],
                    dip_d | exp_st[0] & ~clr_m[0]};
   end

   // status is watched every cycle once reset is released
   always @(negedge ref_clk) begin
      if (live_chk) begin
         `CHK("st_live", exp_st[5:2], status_word[5:2])
         `CHK("status", exp_st, status_word)
      end
   end

   // hang guard: the full run needs well under this many cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 8000) begin
         bad_count++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // gain in v/v for a three-bit code, undefined codes give one
   function automatic logic [5:0] gain_of(input logic [2:0] c);
      return (c < 3'h6) ? 6'(1 << c) : 6'h01;
   endfunction

   // one command with a random host pause in front of it
   task automatic do_cmd(input pmsc_pkg::pmsc_op_t op,
                         input logic [31:0] dd);
      host.xfer(op, dd, $unsigned($random(seed)) % 3, rd, err, ok);
      `CHK("answer", 1'b1, ok)
   endtask

   initial begin
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      live_chk = 1'b1;
      // reset state, pointer parked on an unmapped place
      `CHK("pointer", 16'h0000, addr_pointer)
      `CHK("trim", 8'h42, reference_drift_trim)
      `CHK("gain0", 6'h01, ch0_gain)
      do_cmd(pmsc_pkg::PMSC_OP_READ, 32'h0);
      `CHK("unmapped", 1'b1, err)
      do_cmd(pmsc_pkg::PMSC_OP_SET_PTR, 32'(pmsc_pkg::ADDR_CONFIG));
      do_cmd(pmsc_pkg::PMSC_OP_READ, 32'h0);
      `CHK("cfg reset", 32'h0042_0000, rd)
      // version word is fixed and cannot be written
      do_cmd(pmsc_pkg::PMSC_OP_SET_PTR, 32'(pmsc_pkg::ADDR_VERSION));
      do_cmd(pmsc_pkg::PMSC_OP_WRITE, 32'hFFFF_FFFF);
      `CHK("ver write", 1'b1, err)
      do_cmd(pmsc_pkg::PMSC_OP_READ, 32'h0);
      `CHK("version", {16'h0000, VER}, rd)
      // every gain code on both channels, random other fields
      do_cmd(pmsc_pkg::PMSC_OP_SET_PTR, 32'(pmsc_pkg::ADDR_CONFIG));
      for (int i = 0; i < 16; i++) begin
         d = $random(seed);
         d[26:24] = i[2:0];
         d[29:27] = 3'h7 - i[2:0];
         do_cmd(pmsc_pkg::PMSC_OP_WRITE, d);
         `CHK("cfg err", 1'b0, err)
         do_cmd(pmsc_pkg::PMSC_OP_READ, 32'h0);
         `CHK("cfg", d & pmsc_pkg::CFG_WMASK, rd)
         `CHK("gain0", gain_of(d[26:24]), ch0_gain)
         `CHK("gain1", gain_of(d[29:27]), ch1_gain)
         `CHK("zero", d[6:5], adc_force_zero)
         `CHK("shdn", d[4:3], adc_shutdown)
         `CHK("trim", d[23:16], reference_drift_trim)
      end
      // status refuses writes and keeps the pointer
      do_cmd(pmsc_pkg::PMSC_OP_SET_PTR, 32'(pmsc_pkg::ADDR_STATUS));
      do_cmd(pmsc_pkg::PMSC_OP_WRITE, 32'hFFFF_FFFF);
      `CHK("st write", 1'b1, err)
      `CHK("pointer", pmsc_pkg::ADDR_STATUS, addr_pointer)
      // set and clear in the same cycle: the set must win
      @(negedge ref_clk);
      {ev_d, rise_d, dip_d} = 3'h7;
      do_cmd(pmsc_pkg::PMSC_OP_CLEAR, 32'h0000_0403);
      // random detector traffic with clears mixed in
      for (int k = 0; k < 120; k++) begin
         @(negedge ref_clk);
         {rpol, apol, pwr, cur} = 4'($random(seed));
         ev_d   = ($random(seed) % 8) == 0;
         rise_d = ($random(seed) % 8) == 0;
         dip_d  = ($random(seed) % 8) == 0;
         if (k % 4 == 0)
            do_cmd(pmsc_pkg::PMSC_OP_CLEAR, 32'($random(seed)) & 32'h403);
      end
      // quiet detectors, then the read must match the live word
      @(negedge ref_clk);
      {ev_d, rise_d, dip_d} = 3'h0;
      {rpol, apol, pwr, cur} = 4'hA;
      do_cmd(pmsc_pkg::PMSC_OP_READ, 32'h0);
      `CHK("st read", {16'h0000, exp_st}, rd)
      `CHK("st err", 1'b0, err)
      do_cmd(pmsc_pkg::PMSC_OP_CLEAR, 32'h0000_0403);
      `CHK("cleared", 16'h0000, status_word & 16'h0403)
      stop_test();
   end
endmodule
